// [rtl/asc_host.sv]
// Purpose: Host controller driving an asynchronous 256K x 16 static memory
// Assumes: Memory pins are sampled/driven on the 25 MHz clock
// Notes:   One access at a time; request taken while reqReady is high and a lane is set
//
// Operation
// R01: Write starts only with write strobe, select and a lane strobe all low.
// R02: Memory ends write at first rising edge of write strobe, select or lane.
// R03: Write data valid at least 5 ns before the terminating edge.
// R04: Write data held until the terminating edge; hold 0 ns.
// R05: Address valid at least 7 ns before write end.
// R06: Address valid no later than write start.
// R07: Address stable up to write end; hold 0 ns.
// R08: Lane strobes asserted at least 7 ns before write end.
// R09: Write strobe low time at least setup plus float delay.
// R10: Memory floats the bus at least 3 ns after write strobe rises.
// R11: Memory floats the bus at least 3 ns after select falls.
// R12: Memory may drive the bus as soon as output gate falls.
// R13: Lane data valid within 4.5 ns of lane strobe.
// R14: Memory may drive a lane at once when its strobe falls.
// R15: Memory releases a lane within 6 ns of strobe rising.
// R16: Memory sleeps within 10 ns after select rises.
// R17: Select deasserted before supply enters retention level.
// R18: Lower strobe selects bits 0-7, upper bits 8-15.
// R19: Bus floats when select, output gate or lane strobes are high.
// R20: Space accesses by cycle time; sample read data after access time.
`timescale 1ns/1ps
module asc_host
   import asc_pkg::*;
(
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // User side
   input  wire logic                         reqValid,
   output logic                              reqReady,
   input  wire logic                         reqWrite,
   input  wire logic [asc_pkg::ADDR_W-1:0]   reqAddr,
   input  wire logic [asc_pkg::DATA_W-1:0]   reqWdata,
   input  wire logic [1:0]                   reqLanes,
   input  wire logic                         retentionReq,
   output logic                              retentionOk,
   output logic                              rdValid,
   output logic [asc_pkg::DATA_W-1:0]        rdData,
   // Memory pins
   output logic [asc_pkg::ADDR_W-1:0]        memAddr,
   output logic                              chipSelect_n,
   output logic                              outputGate_n,
   output logic                              writeStrobe_n,
   output logic                              lower_lane_strobe_n,
   output logic                              upper_lane_strobe_n,
   input  wire logic [asc_pkg::DATA_W-1:0]   memDataIn,
   output logic [asc_pkg::DATA_W-1:0]        memDataOut,
   output logic                              memDataOe
);
   import asc_pkg::*;

   // ****************************************
   // Decode helpers
   // ****************************************
   // Write overlap still open for this state and count
   function automatic logic writeOpen(input asc_state_t st, input logic [3:0] cnt);
      return (st == ST_WRITE) && (cnt < WR_PULSE_CYC);
   endfunction

   // Read strobes still low; held past access time for the synchroniser
   function automatic logic readOpen(input asc_state_t st, input logic [3:0] cnt);
      return (st == ST_READ) && (cnt < RD_HOLD_CYC);
   endfunction

   // ****************************************
   // State and registers
   // ****************************************
   asc_state_t                state_reg;
   logic [3:0]                count_reg;
   logic [1:0]                lanes_reg;
   logic [DATA_W-1:0]         sync1_reg;
   logic [DATA_W-1:0]         sync2_reg;
   logic [DATA_W-1:0]         sync3_reg;
   logic                      wasWrite_reg;
   logic                      reqTake;
   logic                      writeOn;
   logic                      readOn;

   // Idle only, and no access while retention is held (R17 margin)
   assign reqReady = (state_reg == ST_IDLE) && !retentionReq;

   // Retention allowed once idle with select high
   assign retentionOk = (state_reg == ST_IDLE) && chipSelect_n; // R17

   // Taken only with a lane asked for; no lane means no write can start
   assign reqTake = reqValid && reqReady && (reqLanes != 2'h0); // R01

   // Strobe phases of the access in progress
   assign writeOn = writeOpen(state_reg, count_reg);
   assign readOn  = readOpen(state_reg, count_reg);

   // ****************************************
   // Sequencer
   // ****************************************
   // Cycle counter limits each phase to its minimum time, reads to access time plus three cycles
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         count_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (reqTake) begin
                  state_reg <= ST_SETUP; // R06
                  count_reg <= 4'h0;
               end
            end
            ST_SETUP: begin
               // Address settled one cycle before any strobe
               state_reg <= wasWrite_reg ? ST_WRITE : ST_READ;
               count_reg <= 4'h1;
            end
            ST_WRITE: begin
               if (count_reg >= WR_PULSE_CYC) begin // R09 R05 R08 R03
                  state_reg <= ST_TURN;
                  count_reg <= 4'h1;
               end else begin
                  count_reg <= count_reg + 4'h1;
               end
            end
            ST_READ: begin
               // Three extra cycles: stage three must hold data taken after access time,
               // otherwise stages two and three disagree and the read is lost
               if (count_reg >= RD_HOLD_CYC) begin // R20
                  state_reg <= ST_TURN;
                  count_reg <= 4'h1;
               end else begin
                  count_reg <= count_reg + 4'h1;
               end
            end
            ST_TURN: begin
               // Lets the memory float the bus before the next access
               if (count_reg >= TURN_CYC && count_reg >= CYCLE_CYC) begin // R15 R20
                  state_reg <= ST_IDLE;
               end else begin
                  count_reg <= count_reg + 4'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               count_reg <= 4'h0;
            end
         endcase
      end
   end

   // ****************************************
   // Request capture and pin drive
   // ****************************************
   // Address and data held from setup until after turnaround
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         memAddr      <= '0;
         memDataOut   <= '0;
         lanes_reg    <= 2'h0;
         wasWrite_reg <= 1'b0;
      end else if (reqTake) begin
         memAddr      <= reqAddr; // R06 R07
         memDataOut   <= reqWdata; // R04
         lanes_reg    <= reqLanes; // R18
         wasWrite_reg <= reqWrite;
      end
   end

   // Control strobes registered so pins are glitch free
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         chipSelect_n        <= 1'b1;
         outputGate_n        <= 1'b1;
         writeStrobe_n       <= 1'b1;
         lower_lane_strobe_n <= 1'b1;
         upper_lane_strobe_n <= 1'b1;
         memDataOe           <= 1'b0;
      end else begin
         // Write ends when all strobes rise together; data still driven
         chipSelect_n        <= !(state_reg == ST_SETUP || writeOn || readOn); // R01 R02 R16
         writeStrobe_n       <= !((state_reg == ST_SETUP && wasWrite_reg) || writeOn); // R01 R02
         // Gate opens only in reads, so host and memory never drive together
         outputGate_n        <= !((state_reg == ST_SETUP && !wasWrite_reg) || readOn); // R12 R19
         // A lane not asked for keeps its strobe high and floats
         lower_lane_strobe_n <= !(lanes_reg[0] && (state_reg == ST_SETUP || writeOn || readOn)); // R18 R13 R14
         upper_lane_strobe_n <= !(lanes_reg[1] && (state_reg == ST_SETUP || writeOn || readOn)); // R18
         // Drive only in writes; held through strobe rise for zero hold
         memDataOe           <= (state_reg == ST_SETUP && wasWrite_reg) || state_reg == ST_WRITE; // R04 R10 R11
      end
   end

   // ****************************************
   // Read data capture
   // ****************************************
   // Three-stage synchroniser on the data pins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= memDataIn;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Stage three is taken only once it matches stage two, so a pin
   // still settling never reaches rdData
   // Sample only after access time and agreement of stages two and three
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdValid <= 1'b0;
         rdData  <= '0;
      end else begin
         rdValid <= 1'b0;
         if (state_reg == ST_READ && count_reg >= RD_HOLD_CYC && sync2_reg == sync3_reg) begin // R20
            rdValid <= 1'b1;
            // Unread lane returns zero, since it floats
            rdData  <= {lanes_reg[1] ? sync3_reg[15:8] : 8'h00, lanes_reg[0] ? sync3_reg[7:0] : 8'h00}; // R18
         end
      end
   end
endmodule

// [rtl/asc_pkg.sv]
// Purpose: Constants for the asynchronous static memory host controller
// Assumes: 25 MHz system clock, 40 ns period
// Notes:   Times in ps; cycle counts derived from them
package asc_pkg;
   localparam int CLK_PERIOD_PS = 40000;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   // Pin timing of the memory, in ps
   localparam int WRITE_DATA_SETUP_PS = 5000;
   localparam int WRITE_DATA_HOLD_PS = 0;
   localparam int ADDR_SETUP_TO_WRITE_END_PS = 7000;
   localparam int ADDR_SETUP_TO_WRITE_START_PS = 0;
   localparam int ADDR_HOLD_AFTER_WRITE_PS = 0;
   localparam int LANE_STROBE_TO_WRITE_END_PS = 7000;
   localparam int WRITE_STROBE_TO_FLOAT_PS = 5000;
   localparam int WRITE_RELEASE_TO_DRIVE_PS = 3000;
   localparam int LANE_RELEASE_TO_FLOAT_PS = 6000;
   localparam int OUTPUT_GATE_TO_FLOAT_PS = 5000;
   localparam int ADDR_TO_DATA_PS = 10000;
   localparam int CYCLE_TIME_PS = 10000;
   localparam int DESELECT_BEFORE_RETENTION_PS = 0;
   // Least time, rounded up, never below one cycle
   function automatic int minCycles(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction
   // Write pulse: setup plus float time, and the 7 ns strobe/address figures
   localparam int WR_PULSE_PS = (WRITE_DATA_SETUP_PS + WRITE_STROBE_TO_FLOAT_PS > ADDR_SETUP_TO_WRITE_END_PS) ?
                                WRITE_DATA_SETUP_PS + WRITE_STROBE_TO_FLOAT_PS : ADDR_SETUP_TO_WRITE_END_PS;
   localparam logic [3:0] WR_PULSE_CYC = 4'(minCycles(WR_PULSE_PS));
   localparam logic [3:0] RD_ACCESS_CYC = 4'(minCycles(ADDR_TO_DATA_PS));
   // Read strobes held until stages two and three of the pin synchroniser both carry the data
   localparam logic [3:0] RD_HOLD_CYC = RD_ACCESS_CYC + 4'h3;
   localparam int TURN_PS = (LANE_RELEASE_TO_FLOAT_PS > OUTPUT_GATE_TO_FLOAT_PS) ?
                            LANE_RELEASE_TO_FLOAT_PS : OUTPUT_GATE_TO_FLOAT_PS;
   localparam logic [3:0] TURN_CYC = 4'(minCycles(TURN_PS));
   localparam logic [3:0] CYCLE_CYC = 4'(minCycles(CYCLE_TIME_PS));
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_WRITE = 5'h04,
      ST_READ  = 5'h08,
      ST_TURN  = 5'h10
   } asc_state_t;
endpackage

// [sim/asc_mem_model.sv]
// Purpose: Behavioural static memory facing the host controller
// Assumes: Word array aliased on the low 10 address bits
// Notes:   Unread lanes show inverted data so stale values never pass
`timescale 1ns/1ps
module asc_mem_model
   import asc_pkg::*;
(
   input  wire logic [asc_pkg::ADDR_W-1:0] memAddr,
   input  wire logic                       chipSelect_n,
   input  wire logic                       outputGate_n,
   input  wire logic                       writeStrobe_n,
   input  wire logic                       lower_lane_strobe_n,
   input  wire logic                       upper_lane_strobe_n,
   input  wire logic [asc_pkg::DATA_W-1:0] memDataOut,
   output logic      [asc_pkg::DATA_W-1:0] memDataIn
);
   logic [15:0] mem [1024];
   logic [15:0] wData;
   logic [9:0]  wAddr;
   logic [1:0]  wLanes;
   logic        armed = 1'b0;
   logic        rdOn;
   // Latch during the overlap, commit on the first rising strobe
   always @(writeStrobe_n, chipSelect_n, lower_lane_strobe_n, upper_lane_strobe_n, memAddr, memDataOut) begin
      if (!writeStrobe_n && !chipSelect_n && !(lower_lane_strobe_n && upper_lane_strobe_n)) begin
         wAddr = memAddr[9:0];
         wData = memDataOut;
         wLanes = ~{upper_lane_strobe_n, lower_lane_strobe_n};
         armed = 1'b1;
      end else if (armed) begin
         if (wLanes[0]) mem[wAddr][7:0] = wData[7:0];
         if (wLanes[1]) mem[wAddr][15:8] = wData[15:8];
         armed = 1'b0;
      end
   end
   // Lane drive with a slow 4 ns access, floats to inverse data
   assign rdOn = !chipSelect_n && !outputGate_n && writeStrobe_n;
   assign #4 memDataIn[7:0] = (rdOn && !lower_lane_strobe_n) ? mem[memAddr[9:0]][7:0] : ~mem[memAddr[9:0]][7:0];
   assign #4 memDataIn[15:8] = (rdOn && !upper_lane_strobe_n) ? mem[memAddr[9:0]][15:8] : ~mem[memAddr[9:0]][15:8];
endmodule

// [sim/asc_host_sva.sv]
// Purpose: Pin timing checks on the host controller
// Assumes: One clock, synchronous active low reset
// Notes:   Bound to every host instance
`timescale 1ns/1ps
module asc_host_sva
   import asc_pkg::*;
(
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic                       reqValid,
   input wire logic                       reqReady,
   input wire logic                       reqWrite,
   input wire logic [1:0]                 reqLanes,
   input wire logic                       retentionOk,
   input wire logic                       rdValid,
   input wire logic [asc_pkg::ADDR_W-1:0] memAddr,
   input wire logic                       chipSelect_n,
   input wire logic                       outputGate_n,
   input wire logic                       writeStrobe_n,
   input wire logic                       lower_lane_strobe_n,
   input wire logic                       upper_lane_strobe_n,
   input wire logic [asc_pkg::DATA_W-1:0] memDataOut,
   input wire logic                       memDataOe
);
   logic take;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Request accepted this edge
   assign take = reqValid && reqReady && (reqLanes != 2'h0);
   property p_write_start; !writeStrobe_n |-> !chipSelect_n && !(lower_lane_strobe_n && upper_lane_strobe_n); endproperty
   a_write_start: assert property (p_write_start) else $error("write strobe without select or lane");
   property p_addr_hold; $past(!chipSelect_n) |-> $stable(memAddr); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved during access");
   property p_data_hold; (!writeStrobe_n || $rose(writeStrobe_n)) |-> memDataOe && $stable(memDataOut); endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data not held");
   property p_all_rise; $rose(writeStrobe_n) |-> chipSelect_n && lower_lane_strobe_n && upper_lane_strobe_n; endproperty
   a_all_rise: assert property (p_all_rise) else $error("strobes ended apart");
   property p_no_fight; !outputGate_n |-> !memDataOe && writeStrobe_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives during read");
   property p_lanes; take |-> ##2 {upper_lane_strobe_n, lower_lane_strobe_n} == ~$past(reqLanes, 2); endproperty
   a_lanes: assert property (p_lanes) else $error("lane strobes differ from request");
   property p_read_done; $fell(outputGate_n) |-> !outputGate_n [*2] ##[1:5] rdValid; endproperty
   a_read_done: assert property (p_read_done) else $error("read data late or sampled early");
   property p_retention; retentionOk && !reqReady |-> chipSelect_n ##1 (retentionOk && chipSelect_n); endproperty
   a_retention: assert property (p_retention) else $error("retention with select low");
   property p_write_go; take && reqWrite |-> ##2 !writeStrobe_n && !chipSelect_n; endproperty
   a_write_go: assert property (p_write_go) else $error("write did not start");
   cover property (take && reqWrite);
   cover property (rdValid);
   cover property (retentionOk && reqValid);
endmodule
bind asc_host asc_host_sva sva_u (.clock, .rst_n, .reqValid, .reqReady, .reqWrite, .reqLanes, .retentionOk, .rdValid,
   .memAddr, .chipSelect_n, .outputGate_n, .writeStrobe_n, .lower_lane_strobe_n, .upper_lane_strobe_n, .memDataOut, .memDataOe);

// [sim/tb.sv]
// Purpose: Self-checking bench for the host controller
// Assumes: Inputs change on the falling edge
// Notes:   Every wait is bounded
`timescale 1ns/1ps
module tb;
   import asc_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, retentionReq = 1'b0;
   logic [ADDR_W-1:0] reqAddr = 18'h0, memAddr;
   logic [DATA_W-1:0] reqWdata = 16'h0, rdData, memDataIn, memDataOut, rdGot;
   logic [1:0] reqLanes = 2'h0;
   logic reqReady, retentionOk, rdValid, chipSelect_n, outputGate_n, writeStrobe_n;
   logic lower_lane_strobe_n, upper_lane_strobe_n, memDataOe;
   int num_errors = 0, checked = 0;
   always #20 clock = ~clock;
   asc_host dut (.clock, .rst_n, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata, .reqLanes, .retentionReq,
      .retentionOk, .rdValid, .rdData, .memAddr, .chipSelect_n, .outputGate_n, .writeStrobe_n, .lower_lane_strobe_n,
      .upper_lane_strobe_n, .memDataIn, .memDataOut, .memDataOe);
   asc_mem_model mem_u (.memAddr, .chipSelect_n, .outputGate_n, .writeStrobe_n, .lower_lane_strobe_n,
      .upper_lane_strobe_n, .memDataOut, .memDataIn);
   task automatic conclude();
      $display("Compares %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // One falling edge, quit once the bound runs out
   task automatic step(inout int n);
      @(negedge clock);
      n++;
      if (n > 30) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, 1'b1, 1'b0);
         conclude();
      end
   endtask
   // One request; a read waits for its data
   task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
      int n;
      n = 0;
      while (reqReady !== 1'b1) step(n);
      {reqValid, reqWrite, reqAddr, reqWdata, reqLanes} = {1'b1, w, a, d, l};
      @(negedge clock);
      reqValid = 1'b0;
      while (!w && rdValid !== 1'b1) step(n);
      rdGot = rdData;
   endtask
   // Byte lanes merge into one word and read back per lane
   task automatic t_lanes();
      access(1'b1, 18'h3ffff, 16'h1234, 2'h3);
      access(1'b1, 18'h3ffff, 16'habcd, 2'h1);
      access(1'b0, 18'h3ffff, 16'h0, 2'h3);
      chk(18'h012cd, {2'h0, rdGot});
      access(1'b0, 18'h3ffff, 16'h0, 2'h2);
      chk(18'h01200, {2'h0, rdGot});
      access(1'b1, 18'h3ffff, 16'h5566, 2'h2);
      access(1'b0, 18'h3ffff, 16'h0, 2'h1);
      chk(18'h000cd, {2'h0, rdGot});
      $display("t_lanes done");
   endtask
   // Back-to-back writes then reads
   task automatic t_b2b();
      access(1'b1, 18'h00001, 16'ha5a5, 2'h3);
      access(1'b1, 18'h00002, 16'h5a5a, 2'h3);
      access(1'b0, 18'h00001, 16'h0, 2'h3);
      chk(18'h0a5a5, {2'h0, rdGot});
      access(1'b0, 18'h00002, 16'h0, 2'h3);
      chk(18'h05a5a, {2'h0, rdGot});
      $display("t_b2b done");
   endtask
   // No lane: nothing starts; retention keeps select high
   task automatic t_idle();
      {reqValid, reqWrite, reqLanes} = {1'b1, 1'b1, 2'h0};
      repeat (3) @(negedge clock);
      chk(18'h3, {16'h0, chipSelect_n, reqReady});
      {retentionReq, reqLanes} = {1'b1, 2'h3};
      repeat (4) @(negedge clock);
      chk(18'h6, {15'h0, retentionOk, chipSelect_n, reqReady});
      {reqValid, retentionReq} = 2'h0;
      @(negedge clock);
      $display("t_idle done");
   endtask
   initial begin
      repeat (16) @(negedge clock);
      chk(18'h1f, {13'h0, chipSelect_n, outputGate_n, writeStrobe_n, lower_lane_strobe_n, upper_lane_strobe_n});
      rst_n = 1'b1;
      t_lanes();
      t_b2b();
      t_idle();
      conclude();
   end
endmodule
